// ==== irt_msg_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module irt_msg_partner (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic slow,
  input  wire logic flush_req,
  output logic      flush_done,
  input  wire logic msg_valid,
  output logic      msg_ready
);
  // ****
  // buffer flush responder and accepting local unit
  // ****
  logic [1:0] fw_q = 2'h0, mw_q = 2'h0;
  logic       fd_q = 1'b0, rd_q = 1'b0;
  assign flush_done = fd_q;
  assign msg_ready  = rd_q;
  // done rises after an optional wait, drops once seen with the request
  always @(posedge clk_sys) begin
    fd_q <= rst_n && flush_req && !fd_q && (!slow || fw_q == 2'h3);
    fw_q <= (rst_n && flush_req && !fd_q) ? fw_q + 2'h1 : 2'h0;
  end
  // ready rises after an optional wait; its edge is the acceptance
  always @(posedge clk_sys) begin
    rd_q <= rst_n && msg_valid && !rd_q && (!slow || mw_q == 2'h3);
    mw_q <= (rst_n && msg_valid && !rd_q) ? mw_q + 2'h1 : 2'h0;
  end
endmodule : irt_msg_partner
`default_nettype wire

// ==== irt_pkg.sv ====
package irt_pkg;

  // ****************************************************************
  // table placement in the indirect offset space
  // ****************************************************************
  localparam logic [7:0] TABLE_BASE    = 8'h10;
  localparam logic [7:0] TABLE_LAST    = 8'h8f;
  localparam int         TABLE_ENTRIES = 64;

  // ****************************************************************
  // low word field positions (entry bits 31:0)
  // ****************************************************************
  localparam int VEC_LSB    = 0;
  localparam int DLV_LSB    = 8;
  localparam int DMODE_BIT  = 11;
  localparam int DSTAT_BIT  = 12;
  localparam int POL_BIT    = 13;
  localparam int RACC_BIT   = 14;
  localparam int TRIG_BIT   = 15;
  localparam int MASK_BIT   = 16;
  localparam int SKIPF_BIT  = 17;

  // ****************************************************************
  // high word field positions (entry bits 63:32)
  // ****************************************************************
  localparam int TID_LSB    = 24;
  localparam int TEID_LSB   = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [63:0] ENTRY_RESET = 64'h0000_0000_0001_0000;
  localparam logic        MASK_RESET  = 1'b1;

  // ****************************************************************
  // delivery mode encodings
  // ****************************************************************
  typedef enum logic [2:0] {
    IRT_DLV_FIXED  = 3'h0,
    IRT_DLV_LOWPRI = 3'h1,
    IRT_DLV_PMGMT  = 3'h2,
    IRT_DLV_RSV3   = 3'h3,
    IRT_DLV_NMI    = 3'h4,
    IRT_DLV_INIT   = 3'h5,
    IRT_DLV_RSV6   = 3'h6,
    IRT_DLV_EXTCTL = 3'h7
  } irt_dlv_t;

  // ****************************************************************
  // dispatcher states, gray along idle -> flush -> send
  // ****************************************************************
  typedef enum logic [1:0] {
    IRT_IDLE  = 2'h0,
    IRT_FLUSH = 2'h1,
    IRT_SEND  = 2'h3
  } irt_state_t;

endpackage : irt_pkg

// ==== irt_redirection_table.sv ====
`timescale 1ns/100ps
`default_nettype none

module irt_redirection_table #(
  parameter int          N_PINS    = 64,
  parameter logic [63:0] BYPASS_A  = 64'h0000_0000_0000_00ff,
  parameter logic [63:0] BYPASS_B  = 64'h0000_0000_0000_ff00,
  parameter logic [63:0] BYPASS_C  = 64'h0000_0000_00ff_0000
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_offset,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  input  wire logic [N_PINS-1:0] irq_pin,
  input  wire logic              streamlined_mode_pin,
  output logic                   flush_req,
  input  wire logic              flush_done,
  output logic                   msg_valid,
  input  wire logic              msg_ready,
  output logic      [7:0]        msg_vector,
  output logic      [2:0]        msg_delivery,
  output logic                   msg_trigger,
  output logic                   msg_dest_mode,
  output logic      [15:0]       msg_target,
  output logic      [5:0]        msg_pin,
  input  wire logic              eos_valid,
  input  wire logic [7:0]        eos_vector,
  output logic                   bypass_output_a,
  output logic                   bypass_output_b,
  output logic                   bypass_output_c
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (N_PINS < 1 || N_PINS > irt_pkg::TABLE_ENTRIES) begin : g_bad_pins
    $error("N_PINS must lie in 1..64");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // pin number addressed by an indirect offset
  function automatic logic [5:0] pin_of(input logic [7:0] off);
    logic [7:0] rel;
    rel = off - irt_pkg::TABLE_BASE;
    return rel[6:1];
  endfunction : pin_of

  // offset falls inside the implemented part of the table
  function automatic logic offset_hit(input logic [7:0] off);
    return (off >= irt_pkg::TABLE_BASE) && (off <= irt_pkg::TABLE_LAST)
           && (int'(pin_of(off)) < N_PINS);
  endfunction : offset_hit

  // lowest set bit of a request vector
  function automatic logic [5:0] first_set(input logic [N_PINS-1:0] v);
    logic [5:0] idx;
    idx = 6'h0;
    for (int k = N_PINS - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = 6'(k);
      end
    end
    return idx;
  endfunction : first_set

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0]        vec_q   [N_PINS];
  logic [2:0]        dlv_q   [N_PINS];
  logic [15:0]       tid_q   [N_PINS];
  logic [N_PINS-1:0] dmode_q;
  logic [N_PINS-1:0] pol_q;
  logic [N_PINS-1:0] trig_q;
  logic [N_PINS-1:0] mask_q;
  logic [N_PINS-1:0] skipf_q;
  logic [N_PINS-1:0] dstat_q;
  logic [N_PINS-1:0] racc_q;
  logic [N_PINS-1:0] pin_meta_q;
  logic [N_PINS-1:0] pin_s_q;
  logic [N_PINS-1:0] act_prev_q;
  logic              mode_meta_q;
  logic              mode_s_q;

  irt_pkg::irt_state_t state_q;
  logic [5:0]          sel_q;

  logic              wr_hit;
  logic [5:0]        wr_pin;
  logic              rd_hit;
  logic [5:0]        rd_pin;
  logic [N_PINS-1:0] act;
  logic [N_PINS-1:0] eff_edge;
  logic [N_PINS-1:0] pend;
  logic              sent;

  assign wr_hit = reg_write && offset_hit(reg_offset);
  assign wr_pin = pin_of(reg_offset);
  assign rd_hit = offset_hit(reg_offset);
  assign rd_pin = pin_of(reg_offset);
  assign sent   = (state_q == irt_pkg::IRT_SEND) && msg_ready;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // two flops on every pin and on the mode strap
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_meta_q  <= '0;
      pin_s_q     <= '0;
      mode_meta_q <= 1'b0;
      mode_s_q    <= 1'b0;
    end else begin
      pin_meta_q  <= irq_pin;
      pin_s_q     <= pin_meta_q;
      mode_meta_q <= streamlined_mode_pin;
      mode_s_q    <= mode_meta_q;
    end
  end

  // ****************************************************************
  // per-pin detection
  // ****************************************************************
  // polarity folds into an active level; non-maskable is edge always
  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      act[i]      = pin_s_q[i] ^ pol_q[i];
      eff_edge[i] = !trig_q[i] || (dlv_q[i] == irt_pkg::IRT_DLV_NMI);
    end
  end

  // eligible requests; reserved types and entries being written are held
  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      pend[i] = !mask_q[i]
                && !(wr_hit && wr_pin == 6'(i))
                && (dlv_q[i] != irt_pkg::IRT_DLV_RSV3)
                && (dlv_q[i] != irt_pkg::IRT_DLV_RSV6)
                && (eff_edge[i] ? dstat_q[i] : (act[i] && !racc_q[i]));
    end
  end

  // previous active level for edge detection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      act_prev_q <= '0;
    end else begin
      act_prev_q <= act;
    end
  end

  // ****************************************************************
  // entry fields written by software
  // ****************************************************************
  // low half on even offset, high half on odd; reserved bits dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < N_PINS; i++) begin
        vec_q[i] <= irt_pkg::ENTRY_RESET[irt_pkg::VEC_LSB +: 8];
        dlv_q[i] <= irt_pkg::ENTRY_RESET[irt_pkg::DLV_LSB +: 3];
        tid_q[i] <= irt_pkg::ENTRY_RESET[32 + irt_pkg::TEID_LSB +: 16];
      end
      dmode_q <= '0;
      pol_q   <= '0;
      trig_q  <= '0;
      mask_q  <= {N_PINS{irt_pkg::MASK_RESET}};
      skipf_q <= '0;
    end else if (wr_hit) begin
      if (!reg_offset[0]) begin
        vec_q[wr_pin]   <= reg_wdata[irt_pkg::VEC_LSB +: 8];
        dlv_q[wr_pin]   <= reg_wdata[irt_pkg::DLV_LSB +: 3];
        dmode_q[wr_pin] <= reg_wdata[irt_pkg::DMODE_BIT];
        pol_q[wr_pin]   <= reg_wdata[irt_pkg::POL_BIT];
        trig_q[wr_pin]  <= reg_wdata[irt_pkg::TRIG_BIT];
        mask_q[wr_pin]  <= reg_wdata[irt_pkg::MASK_BIT];
        skipf_q[wr_pin] <= reg_wdata[irt_pkg::SKIPF_BIT];
      end else begin
        tid_q[wr_pin]   <= reg_wdata[irt_pkg::TEID_LSB +: 16];
      end
    end
  end

  // ****************************************************************
  // delivery status and remote accept
  // ****************************************************************
  // edge latch only while unmasked; a new edge beats the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dstat_q <= '0;
    end else begin
      for (int i = 0; i < N_PINS; i++) begin
        if (act[i] && !act_prev_q[i] && !mask_q[i] && eff_edge[i]) begin
          dstat_q[i] <= 1'b1;
        end else if (sent && sel_q == 6'(i) && eff_edge[i]) begin
          dstat_q[i] <= 1'b0;
        end
      end
    end
  end

  // set on accepted level message; matching end of service clears it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      racc_q <= '0;
    end else begin
      for (int i = 0; i < N_PINS; i++) begin
        if (sent && sel_q == 6'(i) && !eff_edge[i]) begin
          racc_q[i] <= 1'b1;
        end else if (eos_valid && eos_vector == vec_q[i] && trig_q[i]) begin
          racc_q[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // dispatcher
  // ****************************************************************
  // pick lowest pending pin, flush unless its skipf_q bit is set, hold message until taken
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q   <= irt_pkg::IRT_IDLE;
      sel_q     <= 6'h0;
      flush_req <= 1'b0;
      msg_valid <= 1'b0;
    end else begin
      unique case (state_q)
        irt_pkg::IRT_IDLE: begin
          if (|pend) begin
            sel_q <= first_set(pend);
            if (skipf_q[first_set(pend)]) begin
              state_q   <= irt_pkg::IRT_SEND;
              msg_valid <= 1'b1;
            end else begin
              state_q   <= irt_pkg::IRT_FLUSH;
              flush_req <= 1'b1;
            end
          end
        end
        irt_pkg::IRT_FLUSH: begin
          if (flush_done) begin
            flush_req <= 1'b0;
            msg_valid <= 1'b1;
            state_q   <= irt_pkg::IRT_SEND;
          end
        end
        irt_pkg::IRT_SEND: begin
          if (msg_ready) begin
            msg_valid <= 1'b0;
            state_q   <= irt_pkg::IRT_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // message contents
  // ****************************************************************
  // captured from the stored entry when a pin is picked
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      msg_vector    <= 8'h0;
      msg_delivery  <= 3'h0;
      msg_trigger   <= 1'b0;
      msg_dest_mode <= 1'b0;
      msg_target    <= 16'h0;
      msg_pin       <= 6'h0;
    end else if (state_q == irt_pkg::IRT_IDLE && |pend) begin
      msg_pin       <= first_set(pend);
      msg_delivery  <= dlv_q[first_set(pend)];
      msg_trigger   <= !eff_edge[first_set(pend)];
      msg_dest_mode <= dmode_q[first_set(pend)];
      if (dlv_q[first_set(pend)] == irt_pkg::IRT_DLV_NMI ||
          dlv_q[first_set(pend)] == irt_pkg::IRT_DLV_INIT) begin
        msg_vector <= 8'h0;
      end else begin
        msg_vector <= vec_q[first_set(pend)];
      end
      if (mode_s_q) begin
        msg_target <= tid_q[first_set(pend)];
      end else if (dmode_q[first_set(pend)]) begin
        msg_target <= {tid_q[first_set(pend)][15:8], 8'h0};
      end else begin
        msg_target <= {4'h0, tid_q[first_set(pend)][11:8], 8'h0};
      end
    end
  end

  // ****************************************************************
  // bypass routing
  // ****************************************************************
  // masked active pins drive their mapped bypass outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bypass_output_a <= 1'b0;
      bypass_output_b <= 1'b0;
      bypass_output_c <= 1'b0;
    end else begin
      bypass_output_a <= |(act & mask_q & BYPASS_A[N_PINS-1:0]);
      bypass_output_b <= |(act & mask_q & BYPASS_B[N_PINS-1:0]);
      bypass_output_c <= |(act & mask_q & BYPASS_C[N_PINS-1:0]);
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  // reserved bits and unmapped offsets return zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      reg_rdata <= 32'h0;
      if (rd_hit && !reg_offset[0]) begin
        reg_rdata[irt_pkg::VEC_LSB +: 8] <= vec_q[rd_pin];
        reg_rdata[irt_pkg::DLV_LSB +: 3] <= dlv_q[rd_pin];
        reg_rdata[irt_pkg::DMODE_BIT]    <= dmode_q[rd_pin];
        reg_rdata[irt_pkg::DSTAT_BIT]    <= trig_q[rd_pin] ? act[rd_pin]
                                                           : dstat_q[rd_pin];
        reg_rdata[irt_pkg::POL_BIT]      <= pol_q[rd_pin];
        reg_rdata[irt_pkg::RACC_BIT]     <= racc_q[rd_pin];
        reg_rdata[irt_pkg::TRIG_BIT]     <= trig_q[rd_pin];
        reg_rdata[irt_pkg::MASK_BIT]     <= mask_q[rd_pin];
        reg_rdata[irt_pkg::SKIPF_BIT]    <= skipf_q[rd_pin];
      end else if (rd_hit) begin
        reg_rdata[irt_pkg::TID_LSB +: 8]  <= tid_q[rd_pin][15:8];
        reg_rdata[irt_pkg::TEID_LSB +: 8] <= mode_s_q ? tid_q[rd_pin][7:0]
                                                      : 8'h0;
      end
    end
  end

endmodule : irt_redirection_table

`default_nettype wire

// ==== irt_redirection_table_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module irt_redirection_table_monitor #(
  parameter int N_PINS = 64
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_offset,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        flush_req,
  input wire logic        flush_done,
  input wire logic        msg_valid,
  input wire logic        msg_ready,
  input wire logic [7:0]  msg_vector,
  input wire logic [2:0]  msg_delivery,
  input wire logic        msg_trigger,
  input wire logic [15:0] msg_target
);
  // ****
  // message, flush and read-back checks
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic in_tab;
  // offset lies inside the table
  assign in_tab = reg_offset >= 8'h10 && int'(reg_offset) < 16 + 2 * N_PINS;
  sequence s_offer; msg_valid && !msg_ready; endsequence
  sequence s_fl_done; flush_req && flush_done; endsequence
  sequence s_sent; !flush_req && msg_valid; endsequence
  AST_MSG_HOLD: assert property (s_offer |=> msg_valid && $stable({msg_vector, msg_target}))
    else $error("message not held until accepted");
  AST_MSG_DROP: assert property (msg_valid && msg_ready |=> !msg_valid)
    else $error("message offered again after acceptance");
  AST_FLUSH_WAIT: assert property (flush_req && !flush_done |=> flush_req && !msg_valid)
    else $error("flush abandoned or message sent early");
  AST_FLUSH_SEND: assert property (s_fl_done |=> s_sent)
    else $error("no message after flush done");
  AST_NO_RSV: assert property (msg_valid |-> !(msg_delivery inside {3'h3, 3'h6}))
    else $error("reserved delivery mode sent");
  AST_NMI_EDGE: assert property (msg_valid && msg_delivery == 3'h4 |-> !msg_trigger)
    else $error("non-maskable message not edge");
  AST_NO_VEC: assert property (msg_valid && msg_delivery[2:1] == 2'h2 |-> msg_vector == 8'h00)
    else $error("vector carried where it is dropped");
  AST_UNMAPPED: assert property (reg_read && !in_tab |=> reg_rdata == 32'h0)
    else $error("unmapped offset read nonzero");
  AST_RSV_LOW: assert property (reg_read && in_tab && !reg_offset[0] |=> reg_rdata[31:18] == 14'h0)
    else $error("low half reserved bits nonzero");
  AST_RSV_HIGH: assert property (reg_read && in_tab && reg_offset[0] |=> reg_rdata[15:0] == 16'h0)
    else $error("high half reserved bits nonzero");
endmodule : irt_redirection_table_monitor
bind irt_redirection_table irt_redirection_table_monitor #(.N_PINS(N_PINS)) mon_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_offset(reg_offset), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .flush_req(flush_req), .flush_done(flush_done),
  .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_vector(msg_vector),
  .msg_delivery(msg_delivery), .msg_trigger(msg_trigger), .msg_target(msg_target)
);
`default_nettype wire

// ==== irt_redirection_table_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module irt_redirection_table_tb;
  // ****
  // stimulus, capture and scenarios
  // ****
  logic        clk_sys, msg_trigger, flush_req, flush_done, msg_valid, msg_ready, byp_a, m_trig;
  logic        msg_dest_mode, m_dm, byp_b, byp_c;
  logic        rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, smode = 1'b0, slow = 1'b0;
  logic        eos_valid = 1'b0;
  logic [7:0]  reg_offset = 8'h00, eos_vector = 8'h00, msg_vector, m_vec;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, num_errors = 0, comparisons = 0;
  logic [31:0] n_msg = 0, n_exp = 0, nf = 0, cycles = 0;
  logic [63:0] irq_pin = 64'h0;
  logic [2:0]  msg_delivery, m_dlv;
  logic [15:0] msg_target, m_tgt;
  logic [5:0]  msg_pin, m_pin;
  irt_redirection_table irt_redirection_table_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_offset(reg_offset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_pin(irq_pin),
    .streamlined_mode_pin(smode), .flush_req(flush_req), .flush_done(flush_done),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_vector(msg_vector),
    .msg_delivery(msg_delivery), .msg_trigger(msg_trigger), .msg_dest_mode(msg_dest_mode),
    .msg_target(msg_target), .msg_pin(msg_pin), .eos_valid(eos_valid),
    .eos_vector(eos_vector), .bypass_output_a(byp_a), .bypass_output_b(byp_b),
    .bypass_output_c(byp_c)
  );
  irt_msg_partner irt_msg_partner_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .flush_req(flush_req),
    .flush_done(flush_done), .msg_valid(msg_valid), .msg_ready(msg_ready)
  );
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // count cycles, capture accepted messages, cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (flush_req === 1'b1) nf <= nf + 1;
    if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
      n_msg <= n_msg + 1;
      {m_vec, m_dlv, m_trig, m_dm} <= {msg_vector, msg_delivery, msg_trigger, msg_dest_mode};
      {m_tgt, m_pin} <= {msg_target, msg_pin};
    end
    if (cycles == 32'd20000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      num_errors = num_errors + 1;
    end
  endtask : chk
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // one register strobe, one cycle long
  task automatic acc(input logic w, input logic [7:0] o, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_offset, reg_wdata, reg_write, reg_read} <= {o, d, w, !w};
    @(posedge clk_sys);
    {reg_write, reg_read} <= 2'b00;
  endtask : acc
  task automatic rchk(input logic [7:0] o, input logic [31:0] e);
    acc(1'b0, o, 32'h0);
    // read data stands from the strobe edge on; look one edge later
    @(posedge clk_sys);
    chk(reg_rdata, e);
  endtask : rchk
  task automatic prog(input logic [5:0] p, input logic [31:0] lo, input logic [31:0] hi);
    acc(1'b1, {1'b0, p, 1'b0} + 8'h10, lo);
    acc(1'b1, {1'b0, p, 1'b0} + 8'h11, hi);
  endtask : prog
  task automatic wmsg();
    n_exp = n_exp + 1;
    for (int i = 0; i < 40 && n_msg !== n_exp; i++) @(posedge clk_sys);
    chk(n_msg, n_exp);
  endtask : wmsg
  task automatic nomsg();
    repeat (10) @(posedge clk_sys);
    chk(n_msg, n_exp);
  endtask : nomsg
  task automatic eos(input logic [7:0] v);
    @(posedge clk_sys);
    {eos_valid, eos_vector} <= {1'b1, v};
    @(posedge clk_sys);
    eos_valid <= 1'b0;
  endtask : eos
  task automatic t_regs();
    rchk(8'h10, 32'h0001_0000);
    rchk(8'h8e, 32'h0001_0000);
    rchk(8'h90, 32'h0000_0000);
    prog(6'd0, 32'hffff_dfff, 32'hffff_ffff);
    rchk(8'h10, 32'h0003_8fff);
    rchk(8'h11, 32'hff00_0000);
    smode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rchk(8'h11, 32'hffff_0000);
    prog(6'd0, 32'h0001_0000, 32'h0);
  endtask : t_regs
  task automatic t_edge();
    prog(6'd1, 32'h0002_0041, 32'h5a3c_0000);
    irq_pin[1] <= 1'b1;
    wmsg();
    chk({m_vec, m_dlv, m_trig, m_tgt, m_dm, 3'h0}, {8'h41, 3'h0, 1'b0, 16'h5a3c, 1'b0, 3'h0});
    chk(32'(m_pin), 32'h1);
    nomsg();
    rchk(8'h12, 32'h0002_0041);
  endtask : t_edge
  task automatic t_mask();
    prog(6'd2, 32'h0003_0042, 32'h0);
    irq_pin <= irq_pin | 64'h0000_0000_0001_0104;
    nomsg();
    chk(32'({byp_a, byp_b, byp_c}), 32'h7);
    rchk(8'h14, 32'h0003_0042);
    acc(1'b1, 8'h14, 32'h0002_0042);
    nomsg();
    chk(32'({byp_a, byp_b, byp_c}), 32'h3);
  endtask : t_mask
  task automatic t_flush();
    logic [31:0] f0;
    {smode, slow} <= 2'b01;
    prog(6'd3, 32'h0000_0043, 32'hc700_0000);
    f0 = nf;
    irq_pin[3] <= 1'b1;
    wmsg();
    chk(32'(nf > f0 + 32'd3), 32'h1);
    chk({m_vec, m_tgt}, 24'h43_0700);
    slow <= 1'b0;
  endtask : t_flush
  task automatic t_level();
    smode <= 1'b1;
    prog(6'd4, 32'h0002_a077, 32'h1100_0000);
    wmsg();
    chk({m_vec, m_trig}, 9'h0ef);
    rchk(8'h18, 32'h0002_f077);
    nomsg();
    eos(8'h77);
    wmsg();
    irq_pin[4] <= 1'b1;
    // let the pin pass its two synchroniser flops before reading
    repeat (2) @(posedge clk_sys);
    rchk(8'h18, 32'h0002_e077);
    eos(8'h77);
    nomsg();
    rchk(8'h18, 32'h0002_a077);
  endtask : t_level
  // every delivery mode, reserved ones last since their edge latch stays
  task automatic t_modes();
    logic [2:0] ml [8];
    logic [7:0] v;
    ml = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7, 3'h3, 3'h6};
    smode <= 1'b0;
    foreach (ml[i]) begin
      v = (ml[i] == 3'h2) ? 8'h00 : 8'h30 + 8'(ml[i]);
      prog(6'd5, {21'h0, ml[i], v} | 32'h0002_0800, 32'ha5c3_0000);
      irq_pin[5] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      irq_pin[5] <= 1'b0;
      if (i < 6) begin
        wmsg();
        chk({m_dlv, m_tgt, m_trig, m_dm}, {ml[i], 16'ha500, 1'b0, 1'b1});
        chk(32'(m_vec), (i == 3 || i == 4) ? 32'h0 : 32'(v));
      end else begin
        nomsg();
      end
    end
  endtask : t_modes
  // reset, scenarios, a second reset, verdict
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_edge();
    t_mask();
    t_flush();
    t_level();
    t_modes();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(8'h1a, 32'h0001_0000);
    close_out();
  end
endmodule : irt_redirection_table_tb
`default_nettype wire
